// file: src/sar_ctrl_regs.svh
// Constants for the converter control block
`ifndef SAR_CTRL_REGS_SVH
`define SAR_CTRL_REGS_SVH
`define SAR_RESULT_W        16
`define SAR_ERR_BIT         11
`define SAR_HI_LSB          12
`define SAR_CONV_NS         1600
`define SAR_CLK_NS          40
`define SAR_CONV_CYC        ((`SAR_CONV_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_ACQ_NS          400
`define SAR_ACQ_CYC         ((`SAR_ACQ_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CNT_W           8
`define SAR_RESULT_RST      16'h0000
`endif

// file: src/sar_ctrl_pkg.sv
// Types shared by the converter control block
package sar_ctrl_pkg;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_ACQ  = 2'b00,
		ST_CONV = 2'b01,
		ST_DOWN = 2'b10
	} seq_state_t;
	// Mode pins taken together
	typedef struct packed {
		logic fast;
		logic low_power;
		logic power_down;
		logic serial;
		logic ext_clock;
	} mode_t;
endpackage : sar_ctrl_pkg

// file: src/sar_start_detect.sv
// Falling edge detector for the start input
`timescale 1ns/1ps
module sar_start_detect (
	// Clock and reset
	input  wire logic clock_i,
	input  wire logic rstn_i,
	// Start level in, edge out
	input  wire logic convert_start_n_i,
	output logic      fall_o
);
	logic prev_reg; // Last sampled level, idles high

	// Remember previous level
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			prev_reg <= 1'b1;
		else
			prev_reg <= convert_start_n_i;
	end

	// Pulse on high to low step
	assign fall_o = prev_reg & ~convert_start_n_i;
endmodule : sar_start_detect

// file: src/sar_adc_conversion_control.sv
// Conversion sequencer and output pin control of the converter
// Functional notes
// (R1) Parallel mode: shared pin is result bit 11
// (R2) Unfinished slave read at completion: flag pulses
// (R3) Result bits 12 to 15 always outputs; code enables them only with data_oe_n_o (read and select low)
// (R4) Busy high from start until result latched
// (R5) Host may use busy fall as ready
// (R6) Drivers enabled only when read and select low
// (R7) Reset input high aborts conversion
// (R8) Power down: finish current, then refuse starts
// (R9) Start falling edge holds and converts
// (R10) Low power mode: held-low start restarts after acquire; code restarts only while fast is low
// (R11) Clock source select decides serial clock direction
// (R12) Reset returns to acquire, busy and flag low
`timescale 1ns/1ps
`include "sar_ctrl_regs.svh"
module sar_adc_conversion_control #(
	parameter int CONV_CYC = `SAR_CONV_CYC,
	parameter int ACQ_CYC  = `SAR_ACQ_CYC
) (
	// Clock and reset
	input  wire logic                        clock_i,
	input  wire logic                        rstn_i,
	input  wire logic                        reset_i,
	// Control pins
	input  wire logic                        convert_start_n_i,
	input  wire logic                        read_n_i,
	input  wire logic                        chip_select_n_i,
	input  wire sar_ctrl_pkg::mode_t         mode_i,
	// Core result and serial read progress
	input  wire logic [`SAR_RESULT_W-1:0]    core_result_i,
	input  wire logic                        read_started_i,
	input  wire logic                        read_done_i,
	// Pins out
	output logic [`SAR_RESULT_W-1:0]         data_o,
	output logic                             data_oe_n_o,
	output logic                             high_bits_oe_n_o,
	output logic                             busy_o,
	output logic                             hold_o,
	output logic                             low_power_o,
	output logic                             serial_clock_oe_n_o
);
	sar_ctrl_pkg::seq_state_t state_reg;      // Sequencer state
	logic [`SAR_CNT_W-1:0]    count_reg;      // Phase timer
	logic [`SAR_RESULT_W-1:0] result_reg;     // Latched shift register
	logic                     read_open_reg;  // Serial read under way
	logic                     rderr_reg;      // Incomplete read pulse
	logic                     start_fall;     // Start edge
	logic                     clr;            // Synchronous reset level
	logic                     conv_end;       // Last conversion cycle
	logic                     acq_end;        // Acquisition timer done
	logic                     start_ok;       // Start accepted
	logic                     slave_mode;     // Serial external clock
	logic [`SAR_CNT_W-1:0]    busy_len_reg;   // Busy cycles so far, for checks

	// Timer compare helper
	function automatic logic at_count(input logic [`SAR_CNT_W-1:0] c, input int n);
		at_count = (c == n[`SAR_CNT_W-1:0]);
	endfunction : at_count

	// Falling edge of the start pin
	sar_start_detect sar_start_detect_inst (
		.clock_i           (clock_i),
		.rstn_i            (rstn_i),
		.convert_start_n_i (convert_start_n_i),
		.fall_o            (start_fall)
	);

	////////////////////////////////////////////////////////////////////////
	assign clr        = reset_i;                                 // R7
	assign slave_mode = mode_i.serial & mode_i.ext_clock;
	assign conv_end   = (state_reg == sar_ctrl_pkg::ST_CONV) && at_count(count_reg, CONV_CYC - 1);
	assign acq_end    = at_count(count_reg, ACQ_CYC);
	// Edge, or low-power restart when start still held low
	assign start_ok   = (state_reg == sar_ctrl_pkg::ST_ACQ) && !mode_i.power_down && acq_end
		&& (start_fall                                           // R9
		|| (mode_i.low_power && !mode_i.fast && !convert_start_n_i)); // R10

	// Sequencer state
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state_reg <= sar_ctrl_pkg::ST_ACQ;                   // R12
		else if (clr)
			state_reg <= sar_ctrl_pkg::ST_ACQ;                   // R7
		else
		begin
			case (state_reg)
				sar_ctrl_pkg::ST_ACQ:
				begin
					if (mode_i.power_down)
						state_reg <= sar_ctrl_pkg::ST_DOWN;      // R8
					else if (start_ok)
						state_reg <= sar_ctrl_pkg::ST_CONV;      // R9
				end
				sar_ctrl_pkg::ST_CONV:
				begin
					// Current conversion finishes even in power down
					if (conv_end)
						state_reg <= mode_i.power_down ? sar_ctrl_pkg::ST_DOWN
							: sar_ctrl_pkg::ST_ACQ;              // R8
				end
				sar_ctrl_pkg::ST_DOWN:
				begin
					if (!mode_i.power_down)
						state_reg <= sar_ctrl_pkg::ST_ACQ;
				end
				default:
					state_reg <= sar_ctrl_pkg::ST_ACQ;
			endcase
		end
	end

	// Phase timer: counts conversion, then acquisition up to its end
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			count_reg <= '0;
		else if (clr || start_ok || conv_end)
			count_reg <= '0;
		else if (state_reg == sar_ctrl_pkg::ST_CONV)
			count_reg <= count_reg + 1'b1;
		else if (state_reg == sar_ctrl_pkg::ST_ACQ && !acq_end)
			count_reg <= count_reg + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Result latch at end of conversion
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			result_reg <= `SAR_RESULT_RST;
		else if (clr)
			result_reg <= `SAR_RESULT_RST;
		else if (conv_end)
			result_reg <= core_result_i;                         // R4
	end

	// Serial read tracking; a new start of read beats a completion
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			read_open_reg <= 1'b0;
		else if (clr)
			read_open_reg <= 1'b0;
		else if (read_started_i)
			read_open_reg <= 1'b1;
		else if (read_done_i || conv_end)
			read_open_reg <= 1'b0;                               // R2
	end

	// Incomplete read flag, one cycle pulse
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rderr_reg <= 1'b0;                                   // R12
		else if (clr)
			rderr_reg <= 1'b0;
		else
			rderr_reg <= slave_mode && conv_end && read_open_reg && !read_done_i; // R2
	end

	////////////////////////////////////////////////////////////////////////
	// Output pins
	assign busy_o    = (state_reg == sar_ctrl_pkg::ST_CONV);    // R4
	assign hold_o    = busy_o;                                   // R9
	assign low_power_o = (state_reg == sar_ctrl_pkg::ST_DOWN);   // R8
	assign data_oe_n_o = read_n_i | chip_select_n_i;            // R6
	assign high_bits_oe_n_o = data_oe_n_o;                       // R3
	// Serial clock driven only in master serial mode
	assign serial_clock_oe_n_o = !(mode_i.serial && !mode_i.ext_clock); // R11

	// Shared bit 11 carries the flag only in serial slave mode
	always_comb
	begin
		data_o = result_reg;                                     // R1
		if (slave_mode)
			data_o[`SAR_ERR_BIT] = rderr_reg;                    // R2
	end

	////////////////////////////////////////////////////////////////////////
	// Busy length counter, feeds only the busy length check
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			busy_len_reg <= '0;
		else if (busy_o)
			busy_len_reg <= busy_len_reg + 1'b1;
		else
			busy_len_reg <= '0;
	end

	// Start, busy, latch, abort, enable, flag and mode checks; the start, busy and latch checks leave out an aborted conversion
	busy_start_a: assert property (@(posedge clock_i) disable iff (!rstn_i || reset_i) // R9
		start_fall && state_reg == sar_ctrl_pkg::ST_ACQ && acq_end && !mode_i.power_down
		|=> busy_o)
		else $error("busy not raised after start");
	busy_len_a: assert property (@(posedge clock_i) disable iff (!rstn_i || reset_i) // R4
		$fell(busy_o) && !$past(reset_i) |-> at_count(busy_len_reg, CONV_CYC))
		else $error("busy length differs from conversion time");
	latch_a: assert property (@(posedge clock_i) disable iff (!rstn_i || reset_i) // R4
		$fell(busy_o) && !$past(reset_i) |-> result_reg == $past(core_result_i))
		else $error("result not latched at busy fall");
	abort_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R7
		reset_i |=> !busy_o && !rderr_reg)
		else $error("reset did not abort");
	oe_or_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R6
		!data_oe_n_o |-> !read_n_i && !chip_select_n_i)
		else $error("drivers enabled without read and select");
	bit11_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
		!mode_i.serial |-> data_o[`SAR_ERR_BIT] == result_reg[`SAR_ERR_BIT])
		else $error("bit 11 wrong in parallel mode");
	rderr_pulse_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R2
		rderr_reg |=> !rderr_reg)
		else $error("error flag longer than one cycle");
	down_block_a: assert property (@(posedge clock_i) disable iff (!rstn_i || reset_i) // R8
		mode_i.power_down && !busy_o |=> !busy_o)
		else $error("start accepted in power down");
	high_bits_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R3
		high_bits_oe_n_o == data_oe_n_o)
		else $error("high bits enable mismatch");
	sclk_dir_a: assert property (@(posedge clock_i) disable iff (!rstn_i) // R11
		mode_i.ext_clock |-> serial_clock_oe_n_o)
		else $error("serial clock driven in slave mode");

	conv_c: cover property (@(posedge clock_i) disable iff (!rstn_i) $fell(busy_o));
	err_c: cover property (@(posedge clock_i) disable iff (!rstn_i) rderr_reg);
	down_c: cover property (@(posedge clock_i) disable iff (!rstn_i) low_power_o);
	auto_c: cover property (@(posedge clock_i) disable iff (!rstn_i)
		start_ok && !start_fall);
endmodule : sar_adc_conversion_control

// file: dv/sar_host_model.sv
// Host model that starts conversions and collects results on busy fall
`timescale 1ns/1ps
module sar_host_model (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	// Requests from the bench
	input  wire logic        go_i,
	input  wire logic        hold_low_i,
	// Converter side
	input  wire logic        busy_i,
	input  wire logic [15:0] data_i,
	output logic             convert_start_n_o,
	output logic [15:0]      last_data_o
);
	logic busy_reg; // Busy as seen at the previous edge
	// Start level: low one cycle per request, or held low
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			convert_start_n_o <= 1'b1;
		else
			convert_start_n_o <= !(go_i || hold_low_i);
	end
	// Busy fall taken as the data ready strobe
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			busy_reg <= 1'b0;
		else
			busy_reg <= busy_i;
	end
	// Result copy taken on the ready strobe
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			last_data_o <= 16'h0000;
		else if (busy_reg && !busy_i)
			last_data_o <= data_i;
	end
endmodule : sar_host_model

// file: dv/tb_sar_adc_conversion_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_sar_adc_conversion_control;
	localparam int CONV = 4; // Shortened conversion length
	localparam int ACQ  = 2; // Shortened acquisition length
	logic                clock_i, rstn_i, reset_i, start_n, read_n_i, cs_n, go, hold;
	logic                started, done, data_oe_n, high_oe_n, busy_o, hold_o, low_power_o, sck_oe_n;
	sar_ctrl_pkg::mode_t mode;       // Mode pins
	logic [15:0]         core, data_o, last_data; // Core result, pins, host copy
	int                  num_errors, checks, i;
	sar_adc_conversion_control #(.CONV_CYC(CONV), .ACQ_CYC(ACQ)) sar_adc_conversion_control_inst (
		.clock_i(clock_i), .rstn_i(rstn_i), .reset_i(reset_i), .convert_start_n_i(start_n),
		.read_n_i(read_n_i), .chip_select_n_i(cs_n), .mode_i(mode), .core_result_i(core),
		.read_started_i(started), .read_done_i(done), .data_o(data_o), .data_oe_n_o(data_oe_n),
		.high_bits_oe_n_o(high_oe_n), .busy_o(busy_o), .hold_o(hold_o),
		.low_power_o(low_power_o), .serial_clock_oe_n_o(sck_oe_n));
	sar_host_model sar_host_model_inst (.clock_i(clock_i), .rstn_i(rstn_i), .go_i(go),
		.hold_low_i(hold), .busy_i(busy_o), .data_i(data_o),
		.convert_start_n_o(start_n), .last_data_o(last_data));
	////////////////////////////////////////////////////////////////////////////////
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			num_errors++;
	endtask : chk
	// Expected shared bit 11 after a conversion
	function automatic logic exp_bit11(input logic slave, input logic open_rd,
		input logic [15:0] res);
		exp_bit11 = slave ? open_rd : res[11];
	endfunction : exp_bit11
	// Step to just after the next rising edge
	task automatic tick();
		@(posedge clock_i);
		#1;
	endtask : tick
	// Summary and end of run
	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// One conversion with a serial read left open or closed, power down optional
	task automatic conv(input bit open_rd, input bit pwr_dn);
		int  n;
		int  w;
		logic se;
		se = mode.serial && mode.ext_clock;
		core = 16'($urandom);
		go = 1'b1;
		tick();
		go = 1'b0;
		for (w = 0; w < 20 && !busy_o; w++) tick();
		chk(hold_o, 1'b1);
		mode.power_down = pwr_dn;
		started = 1'b1;
		tick();
		started = 1'b0;
		done = !open_rd;
		tick();
		done = 1'b0;
		for (n = 2; n < 200 && busy_o; n++) tick();
		chk(16'(n), 16'(CONV));
		chk(data_o & 16'hf7ff, core & 16'hf7ff);
		chk(data_o[11], exp_bit11(se, open_rd, core));
		chk(hold_o, 1'b0);
		tick();
		if (se) chk(data_o[11], 1'b0);
		chk(last_data & 16'hf7ff, core & 16'hf7ff);
		chk(low_power_o, pwr_dn);
		repeat (ACQ + 2) tick();
	endtask : conv
	// Output enables follow the read and select pins, serial clock enable the mode pins
	task automatic oe();
		read_n_i = 1'($urandom);
		cs_n = 1'($urandom);
		tick();
		chk(data_oe_n, read_n_i | cs_n);
		chk(high_oe_n, read_n_i | cs_n);
		chk(sck_oe_n, !(mode.serial && !mode.ext_clock));
	endtask : oe
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	// Hang guard
	initial
	begin
		#200000;
		num_errors++;
		print_verdict();
	end
	// Main sequence
	initial
	begin
		{rstn_i, reset_i, read_n_i, cs_n, go, hold, started, done} = 8'h30;
		mode = '0;
		core = 16'h0000;
		void'($urandom(32'h12bc2868));
		repeat (20) @(posedge clock_i);
		#1 rstn_i = 1'b1;
		chk(data_o, 16'h0000);
		chk(busy_o, 1'b0);
		repeat (ACQ + 2) tick();
		for (i = 0; i < 16; i++)
		begin
			mode = sar_ctrl_pkg::mode_t'(5'($urandom) & 5'h03);
			oe();
			conv(i[0], 1'b0);
		end
		// Sync reset in mid conversion
		go = 1'b1;
		tick();
		go = 1'b0;
		repeat (3) tick();
		reset_i = 1'b1;
		tick();
		chk(busy_o, 1'b0);
		chk(data_o, 16'h0000);
		reset_i = 1'b0;
		repeat (ACQ + 2) tick();
		// Power down mid conversion, then starts refused
		mode = '0;
		conv(1'b0, 1'b1);
		go = 1'b1;
		tick();
		go = 1'b0;
		repeat (10) tick();
		chk(busy_o, 1'b0);
		mode.power_down = 1'b0;
		repeat (ACQ + 3) tick();
		// Low power mode restarts while start stays low
		mode.low_power = 1'b1;
		hold = 1'b1;
		conv(1'b0, 1'b0);
		chk(busy_o, 1'b1);
		hold = 1'b0;
		repeat (CONV + ACQ + 4) tick();
		// Fast select blocks the held-low restart
		mode.fast = 1'b1;
		hold = 1'b1;
		conv(1'b0, 1'b0);
		chk(busy_o, 1'b0);
		hold = 1'b0;
		tick();
		print_verdict();
	end
endmodule : tb_sar_adc_conversion_control
